// *** bench/scp_host_model.sv ***
// Behavioural SPI host: chip select, serial clock and write data
`timescale 1ns/1ps
module scp_host_model (
   input  wire logic ref_clk,
   input  wire logic din,
   output logic      cs_n,
   output logic      sclk,
   output logic      dout
);
   initial begin
      cs_n = 1'b1;
      sclk = 1'b0;
      dout = 1'b0;
   end
   task automatic tick(input int n);
      repeat (n) @(posedge ref_clk);
   endtask
   task automatic sel();
      cs_n <= 1'b0;
      tick(13);
   endtask
   // Raised only on byte boundaries unless an abort is wanted
   task automatic desel();
      cs_n <= 1'b1;
      tick(13);
   endtask
   // 125 ns bit time, far below the clock ceiling
   task automatic shift(input logic [15:0] v, input int n, input logic lsb, input logic drive,
                        output logic [15:0] got);
      got = 16'h0000;
      for (int i = 0; i < n; i++) begin
         // Released line toggles so a stale bit never reads as valid
         dout <= drive ? (lsb ? v[i] : v[n-1-i]) : ~dout;
         tick(13);
         sclk <= 1'b1;
         tick(12);
         if (lsb)
            got[i] = din;
         else
            got[n-1-i] = din;
         sclk <= 1'b0;
      end
   endtask
endmodule

// *** bench/scp_top_asserts.sv ***
// Concurrent checks on the serial control port pins and buffer side
`timescale 1ns/1ps
module scp_top_asserts (
   input wire logic       ref_clk,
   input wire logic       srst,
   input wire logic       addr_strap_upper,
   input wire logic       addr_strap_lower,
   input wire logic       cs_n,
   input wire logic       sdio_oe,
   input wire logic       sdo_oe,
   input wire logic [6:0] i2c_target_addr,
   input wire logic       lsb_first,
   input wire logic       unidir_mode,
   input wire logic       buf_wr_valid,
   input wire logic       buf_wr_ready,
   input wire logic [7:0] buf_wr_data,
   input wire logic       wr_overrun,
   input wire logic       rd_req
);
   default clocking @(posedge ref_clk); endclocking
   default disable iff (srst);
   // Six cycles covers the chip select synchroniser plus the release delay
   a_cs_release: assert property (cs_n [*6] |-> !sdio_oe && !sdo_oe)
      else $error("data output driven while chip select high");
   a_sdio_mode: assert property (sdio_oe |-> !unidir_mode)
      else $error("shared line driven in four-wire mode");
   a_sdo_mode: assert property (sdo_oe |-> unidir_mode)
      else $error("separate output driven in three-wire mode");
   a_i2c_addr: assert property (($stable({addr_strap_upper, addr_strap_lower})) [*6]
      |-> i2c_target_addr == {scp_pkg::I2C_ADDR_HI, addr_strap_upper, addr_strap_lower})
      else $error("two-wire address does not follow straps");
   a_reset_cfg: assert property ($fell(srst) |-> !lsb_first && !unidir_mode && !sdio_oe && !sdo_oe)
      else $error("port not in three-wire msb-first after reset");
   a_fifo_hold: assert property (buf_wr_valid && !buf_wr_ready |=> buf_wr_valid && $stable(buf_wr_data))
      else $error("buffer head changed while stalled");
   a_overrun_full: assert property (wr_overrun |-> buf_wr_valid ##1 !wr_overrun)
      else $error("overrun without full buffer or not a pulse");
   a_rd_pulse: assert property (rd_req |=> (!rd_req) [*8])
      else $error("read request not a lone pulse");
endmodule

bind scp_top scp_top_asserts chk_i (
   .ref_clk(ref_clk), .srst(srst), .addr_strap_upper(addr_strap_upper), .addr_strap_lower(addr_strap_lower),
   .cs_n(cs_n), .sdio_oe(sdio_oe), .sdo_oe(sdo_oe), .i2c_target_addr(i2c_target_addr), .lsb_first(lsb_first),
   .unidir_mode(unidir_mode), .buf_wr_valid(buf_wr_valid), .buf_wr_ready(buf_wr_ready),
   .buf_wr_data(buf_wr_data), .wr_overrun(wr_overrun), .rd_req(rd_req));

// *** bench/testbench.sv ***
// Self-checking bench around the serial control port
`timescale 1ns/1ps
module testbench;
   logic        ref_clk, cs_n, sclk, hd, din, sdio_in, sdio_out, sdio_oe, sdo_out, sdo_oe;
   logic        spi_sel, lsb, uni, busy, bv, ovr, rd_req, rd_src;
   logic        srst = 1'b1, strap = 1'b0, s_up = 1'b0, s_lo = 1'b0, ready = 1'b0, act_sel = 1'b0;
   logic [6:0]  i2c_addr;
   logic [12:0] ba, rd_addr;
   logic [7:0]  bd;
   logic [7:0]  rd_data = 8'h00;
   logic [7:0]  pay [8];
   logic [7:0]  got [8];
   int          bad_count = 0;
   int          comparisons = 0;
   int          ovr_cnt = 0;

   initial begin
      ref_clk = 1'b0;
      forever #2.5 ref_clk = ~ref_clk;
   end
   assign sdio_in = sdio_oe ? sdio_out : hd;
   assign din = sdo_oe ? sdo_out : (sdio_oe ? sdio_out : 1'bz);
   // Register file stand-in, answers one cycle after the request
   always @(posedge ref_clk) rd_data <= rd_addr[7:0] ^ 8'h5a;
   always @(posedge ref_clk)
      if (ovr === 1'b1)
         ovr_cnt <= ovr_cnt + 1;

   scp_host_model host (.ref_clk(ref_clk), .din(din), .cs_n(cs_n), .sclk(sclk), .dout(hd));
   scp_top #(.FIFO_DEPTH(4)) dut (
      .ref_clk(ref_clk), .srst(srst), .interface_select_strap(strap), .addr_strap_upper(s_up),
      .addr_strap_lower(s_lo), .cs_n(cs_n), .sclk(sclk), .sdio_in(sdio_in), .sdio_out(sdio_out),
      .sdio_oe(sdio_oe), .sdo_out(sdo_out), .sdo_oe(sdo_oe), .spi_selected(spi_sel),
      .i2c_target_addr(i2c_addr), .lsb_first(lsb), .unidir_mode(uni), .busy(busy), .buf_wr_valid(bv),
      .buf_wr_ready(ready), .buf_wr_addr(ba), .buf_wr_data(bd), .wr_overrun(ovr),
      .readback_active_sel(act_sel), .rd_req(rd_req), .rd_addr(rd_addr), .rd_src_active(rd_src),
      .rd_data(rd_data));

   task automatic chk(input string nm, input logic [20:0] e, input logic [20:0] s);
      comparisons++;
      if (s !== e) begin
         bad_count++;
         $display("unexpected %s: expected %h, seen %h", nm, e, s);
      end
   endtask
   task automatic wrap_up();
      $display("comparisons %0d, mismatches %0d", comparisons, bad_count);
      if (bad_count == 0 && comparisons > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask
   task automatic xfer(input logic rd, input logic [1:0] cnt, input logic [12:0] a, input int nb,
                       input logic stall, input logic lf);
      logic [15:0] g;
      host.sel();
      host.shift({rd, cnt, a}, 16, lf, 1'b1, g);
      for (int j = 0; j < nb; j++) begin
         if (stall && j > 0) begin
            host.desel();
            host.sel();
         end
         host.shift({8'h00, pay[j]}, 8, lf, !rd, g);
         got[j] = g[7:0];
      end
      host.desel();
   endtask
   // Pops n words, addresses stepping down from a0
   task automatic drain(input logic [12:0] a0, input int n);
      int k;
      for (int j = 0; j < n; j++) begin
         for (k = 0; k < 300 && bv !== 1'b1; k++) @(posedge ref_clk);
         if (k == 300) begin
            bad_count++;
            wrap_up();
         end
         chk("fifo word", {a0 - 13'(j), pay[j]}, {ba, bd});
         ready <= 1'b1;
         @(posedge ref_clk);
         ready <= 1'b0;
         @(posedge ref_clk);
      end
   endtask

   initial begin
      logic [15:0] g;
      repeat (2) @(posedge ref_clk);
      srst <= 1'b0;
      repeat (6) @(posedge ref_clk);
      chk("lsb first", 1'b0, lsb);
      chk("unidir", 1'b0, uni);
      for (int k = 0; k < 4; k++) begin
         s_up <= k[1];
         s_lo <= k[0];
         strap <= k[0];
         repeat (8) @(posedge ref_clk);
         chk("i2c address", {5'h1b, k[1], k[0]}, i2c_addr);
         chk("spi selected", k[0] == scp_pkg::STRAP_SPI_LVL, spi_sel);
      end
      strap <= 1'b0;
      repeat (8) @(posedge ref_clk);
      // Counts one to three; the three-byte case stalls between bytes
      for (int c = 0; c < 3; c++) begin
         for (int j = 0; j < 3; j++) pay[j] = 8'h31 + 8'(4 * c + j);
         xfer(1'b0, 2'(c), 13'h0100, c + 1, c == 2, 1'b0);
         drain(13'h0100, c + 1);
         chk("fifo empty", 1'b0, bv);
      end
      // Five streamed bytes into four words with the drain side stalled
      for (int j = 0; j < 5; j++) pay[j] = 8'ha0 + 8'(j);
      xfer(1'b0, scp_pkg::CNT_STREAM, 13'h0050, 5, 1'b0, 1'b0);
      chk("overrun pulses", 21'd1, 21'(ovr_cnt));
      drain(13'h0050, 4);
      chk("fifo empty", 1'b0, bv);
      host.sel();
      host.shift(16'h0060, 16, 1'b0, 1'b1, g);
      host.shift(16'h00ff, 3, 1'b0, 1'b1, g);
      host.desel();
      chk("busy after abort", 1'b0, busy);
      chk("fifo after abort", 1'b0, bv);
      pay[0] = 8'h5c;
      xfer(1'b0, 2'h0, 13'h0061, 1, 1'b0, 1'b0);
      drain(13'h0061, 1);
      act_sel <= 1'b1;
      xfer(1'b1, 2'h1, 13'h0020, 2, 1'b0, 1'b0);
      chk("read byte 0", 8'h20 ^ 8'h5a, got[0]);
      chk("read byte 1", 8'h1f ^ 8'h5a, got[1]);
      chk("readback source", 1'b1, rd_src);
      pay[0] = 8'hc0;
      xfer(1'b0, 2'h0, scp_pkg::CFG_ADDR, 1, 1'b0, 1'b0);
      chk("lsb first", 1'b1, lsb);
      chk("unidir", 1'b1, uni);
      chk("fifo after config", 1'b0, bv);
      act_sel <= 1'b0;
      xfer(1'b1, 2'h2, 13'h0040, 3, 1'b1, 1'b1);
      for (int j = 0; j < 3; j++) chk("lsb read", 8'(8'h40 + j) ^ 8'h5a, got[j]);
      chk("readback source", 1'b0, rd_src);
      xfer(1'b1, 2'h0, scp_pkg::CFG_ADDR, 1, 1'b0, 1'b1);
      chk("config readback", 8'hc0, got[0]);
      wrap_up();
   end
endmodule

// *** design/scp_pkg.sv ***
// Shared constants for the serial control port
package scp_pkg;
   localparam int          ADDR_W        = 13;
   localparam int          BYTE_W        = 8;
   localparam int          INSTR_W       = 16;
   localparam int          WORD_W        = ADDR_W + BYTE_W;
   localparam int          FIFO_DEPTH    = 4;
   // Instruction word layout
   localparam int          RW_BIT        = 15;
   localparam int          CNT_HI_BIT    = 14;
   localparam int          CNT_LO_BIT    = 13;
   localparam logic [1:0]  CNT_STREAM    = 2'h3;
   // Bit counter marks
   localparam logic [3:0]  INSTR_LAST    = 4'hf;
   localparam logic [3:0]  BYTE_LAST     = 4'h7;
   localparam logic [3:0]  CNT_ZERO      = 4'h0;
   localparam logic [3:0]  CNT_ONE       = 4'h1;
   // Port configuration register, kept inside the port
   localparam logic [12:0] CFG_ADDR      = 13'h0000;
   localparam logic [12:0] ADDR_ONE      = 13'h0001;
   localparam int          CFG_LSB_BIT   = 6;
   localparam int          CFG_UNI_BIT   = 7;
   localparam logic [7:0]  CFG_RESET     = 8'h00;
   // Target address for the two-wire port
   localparam logic [4:0]  I2C_ADDR_HI   = 5'h1b;
   // Strap level that selects the SPI port
   localparam logic        STRAP_SPI_LVL = 1'b0;
   // Host clock limit, in Hz, and the least sample cycles per half period
   localparam longint      REF_HZ        = 200000000;
   localparam longint      SCLK_MAX_HZ   = 40000000;
   localparam int          HALF_CYC      = int'(REF_HZ / (2 * SCLK_MAX_HZ));

   typedef enum logic [3:0] {
      SCP_IDLE  = 4'b0001,
      SCP_INSTR = 4'b0010,
      SCP_DATA  = 4'b0100,
      SCP_STALL = 4'b1000
   } scp_state_t;
endpackage

// *** design/scp_top.sv ***
// Serial control port target with write buffer FIFO
//
// Function
// [RULE1] Strap level selects the SPI port or the two-wire port.
// [RULE2] Two-wire target address is 11011 followed by the two address straps.
// [RULE3] Write bits captured on rising clock, read bits shifted on falling clock.
// [RULE4] Host keeps the serial clock at or below 40 MHz.
// [RULE5] Three-wire mode drives read data on shared line; four-wire keeps it input.
// [RULE6] Separate data output drives read data only in four-wire mode.
// [RULE7] Both data outputs released while chip select is high.
// [RULE8] After reset: three-wire, MSB first.
// [RULE9] Chip select falling starts a transaction and instruction decode.
// [RULE10] Short transfers may stall on byte boundaries; resume on chip select fall.
// [RULE11] Abort: finish, or toggle chip select with one to seven clocks.
// [RULE12] Chip select rising mid-byte ends transfer, flushes partial data, resets port.
// [RULE13] Streaming moves unlimited bytes, stepping address each byte, ended by chip select.
// [RULE14] Byte count field: 0,1,2 give 1,2,3 bytes; 3 means streaming.
// [RULE15] Sixteen-bit instruction on first sixteen rising edges, then payload.
// [RULE16] Instruction gives direction, byte count and first address.
// [RULE17] Written bytes go to the buffer registers, not active registers.
// [RULE18] Host writes proper values to reserved and zeros to blank addresses.
// [RULE19] Read shifts out N bytes from the given address; long instruction only.
// [RULE20] Read data valid at falling edges; blank addresses returned in sequence.
// [RULE21] Readback comes from buffer or active registers.
// [RULE22] Configuration register at address zero lives inside the port.
// [RULE23] Instruction: read flag on top, two count bits, 13-bit address.
// [RULE24] Configuration bit 6 set selects LSB first from the next operation.
// [RULE25] MSB first: address decrements after each payload byte.
// [RULE26] LSB first: address increments after each payload byte.
// [RULE27] Chip select rising after a finished transfer returns the port to idle.
`timescale 1ns/1ps

module scp_fifo #(
   parameter int WIDTH = 8,
   parameter int DEPTH = 4
) (
   input  wire logic             ref_clk,
   input  wire logic             srst,
   input  wire logic             in_valid,
   output logic                  in_ready,
   input  wire logic [WIDTH-1:0] in_data,
   output logic                  out_valid,
   input  wire logic             out_ready,
   output logic [WIDTH-1:0]      out_data
);
   localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

   logic [WIDTH-1:0] mem_reg [DEPTH];
   logic [PW-1:0]    wp_reg;
   logic [PW-1:0]    rp_reg;
   logic [PW:0]      cnt_reg;
   logic             push;
   logic             pop;

   assign in_ready  = (cnt_reg != (PW+1)'(DEPTH));
   assign out_valid = (cnt_reg != '0);
   assign out_data  = mem_reg[rp_reg];
   assign push      = in_valid & in_ready;
   assign pop       = out_valid & out_ready;

   function automatic logic [PW-1:0] ptr_inc(input logic [PW-1:0] p);
      ptr_inc = (p == PW'(DEPTH - 1)) ? '0 : p + PW'(1);
   endfunction

   always_ff @(posedge ref_clk) begin
      if (push) begin
         mem_reg[wp_reg] <= in_data;
      end
   end

   always_ff @(posedge ref_clk) begin
      if (srst) begin
         wp_reg  <= '0;
         rp_reg  <= '0;
         cnt_reg <= '0;
      end else begin
         if (push) begin
            wp_reg <= ptr_inc(wp_reg);
         end
         if (pop) begin
            rp_reg <= ptr_inc(rp_reg);
         end
         if (push && !pop) begin
            cnt_reg <= cnt_reg + (PW+1)'(1);
         end else if (pop && !push) begin
            cnt_reg <= cnt_reg - (PW+1)'(1);
         end
      end
   end
endmodule

module scp_top #(
   parameter int FIFO_DEPTH = scp_pkg::FIFO_DEPTH
) (
   input  wire logic                       ref_clk,
   input  wire logic                       srst,
   input  wire logic                       interface_select_strap,
   input  wire logic                       addr_strap_upper,
   input  wire logic                       addr_strap_lower,
   input  wire logic                       cs_n,
   input  wire logic                       sclk,
   input  wire logic                       sdio_in,
   output logic                            sdio_out,
   output logic                            sdio_oe,
   output logic                            sdo_out,
   output logic                            sdo_oe,
   output logic                            spi_selected,
   output logic [6:0]                      i2c_target_addr,
   output logic                            lsb_first,
   output logic                            unidir_mode,
   output logic                            busy,
   output logic                            buf_wr_valid,
   input  wire logic                       buf_wr_ready,
   output logic [scp_pkg::ADDR_W-1:0]      buf_wr_addr,
   output logic [scp_pkg::BYTE_W-1:0]      buf_wr_data,
   output logic                            wr_overrun,
   input  wire logic                       readback_active_sel,
   output logic                            rd_req,
   output logic [scp_pkg::ADDR_W-1:0]      rd_addr,
   output logic                            rd_src_active,
   input  wire logic [scp_pkg::BYTE_W-1:0] rd_data
);
   // Pin synchronisers; stage one feeds only stage two
   logic [2:0] sclk_sync_reg;
   logic [2:0] cs_sync_reg;
   logic [1:0] sdio_sync_reg;
   logic [1:0] sel_sync_reg;
   logic [1:0] up_sync_reg;
   logic [1:0] lo_sync_reg;

   scp_pkg::scp_state_t               state_reg;
   logic [3:0]                        bit_cnt_reg;
   logic [scp_pkg::INSTR_W-1:0]       instr_reg;
   logic [scp_pkg::INSTR_W-1:0]       instr_next;
   logic [scp_pkg::BYTE_W-1:0]        rx_reg;
   logic [scp_pkg::BYTE_W-1:0]        rx_next;
   logic [scp_pkg::BYTE_W-1:0]        tx_reg;
   logic [scp_pkg::BYTE_W-1:0]        cfg_reg;
   logic [scp_pkg::ADDR_W-1:0]        addr_reg;
   logic [1:0]                        left_reg;
   logic                              stream_reg;
   logic                              rw_reg;
   logic                              op_lsb_reg;
   logic                              instr_done_reg;
   logic                              xfer_done_reg;
   logic                              rd_load_reg;
   logic                              tx_bit_reg;
   logic                              oe_reg;
   logic                              rd_end_reg;
   logic                              sdio_oe_reg;
   logic                              sdo_oe_reg;
   logic                              rd_req_reg;
   logic [scp_pkg::ADDR_W-1:0]        rd_addr_reg;
   logic                              rd_src_reg;
   logic                              push_reg;
   logic [scp_pkg::WORD_W-1:0]        push_word_reg;
   logic                              overrun_reg;
   logic                              spi_sel_reg;
   logic [6:0]                        i2c_addr_reg;
   logic                              busy_reg;

   logic                              sclk_rise;
   logic                              sclk_fall;
   logic                              cs_fall;
   logic                              cs_rise;
   logic                              din;
   logic                              cs_low;
   logic                              fifo_in_ready;
   logic                              fifo_out_valid;
   logic [scp_pkg::WORD_W-1:0]        fifo_out_data;
   logic [scp_pkg::ADDR_W-1:0]        next_addr;
   logic [scp_pkg::ADDR_W-1:0]        first_addr;

   assign sclk_rise  = sclk_sync_reg[1] & ~sclk_sync_reg[2];
   assign sclk_fall  = ~sclk_sync_reg[1] & sclk_sync_reg[2];
   assign cs_fall    = ~cs_sync_reg[1] & cs_sync_reg[2];
   assign cs_rise    = cs_sync_reg[1] & ~cs_sync_reg[2];
   assign cs_low     = ~cs_sync_reg[1];
   assign din        = sdio_sync_reg[1];

   // Byte count field: 3 streams, else a field value of N gives N more bytes after the first
   function automatic logic is_stream(input logic [1:0] cnt);
      is_stream = (cnt == scp_pkg::CNT_STREAM);
   endfunction

   // One serial bit into a shift register, order chosen by the mode
   function automatic logic [7:0] shift8(input logic [7:0] sh, input logic d, input logic lsb);
      shift8 = lsb ? {d, sh[7:1]} : {sh[6:0], d};
   endfunction

   function automatic logic [15:0] shift16(input logic [15:0] sh, input logic d, input logic lsb);
      shift16 = lsb ? {d, sh[15:1]} : {sh[14:0], d};
   endfunction

   function automatic logic [12:0] step_addr(input logic [12:0] a, input logic lsb);
      step_addr = lsb ? a + scp_pkg::ADDR_ONE : a - scp_pkg::ADDR_ONE;
   endfunction

   assign instr_next = shift16(instr_reg, din, op_lsb_reg);               // [RULE15]
   assign rx_next    = shift8(rx_reg, din, op_lsb_reg);
   assign first_addr = instr_next[scp_pkg::ADDR_W-1:0];                  // [RULE23]
   assign next_addr  = step_addr(addr_reg, op_lsb_reg);                  // [RULE25] [RULE26]

   always_ff @(posedge ref_clk) begin
      if (srst) begin
         sclk_sync_reg <= '0;
         cs_sync_reg   <= 3'h7;
         sdio_sync_reg <= '0;
         sel_sync_reg  <= '0;
         up_sync_reg   <= '0;
         lo_sync_reg   <= '0;
      end else begin
         sclk_sync_reg <= {sclk_sync_reg[1:0], sclk};
         cs_sync_reg   <= {cs_sync_reg[1:0], cs_n};
         sdio_sync_reg <= {sdio_sync_reg[0], sdio_in};
         sel_sync_reg  <= {sel_sync_reg[0], interface_select_strap};
         up_sync_reg   <= {up_sync_reg[0], addr_strap_upper};
         lo_sync_reg   <= {lo_sync_reg[0], addr_strap_lower};
      end
   end

   // Port selection and two-wire target address from the straps
   always_ff @(posedge ref_clk) begin
      if (srst) begin
         spi_sel_reg  <= 1'b0;
         i2c_addr_reg <= '0;
      end else begin
         spi_sel_reg  <= (sel_sync_reg[1] == scp_pkg::STRAP_SPI_LVL);           // [RULE1]
         i2c_addr_reg <= {scp_pkg::I2C_ADDR_HI, up_sync_reg[1], lo_sync_reg[1]}; // [RULE2]
      end
   end

   // Transfer sequencer
   always_ff @(posedge ref_clk) begin
      if (srst || !spi_sel_reg) begin
         state_reg      <= scp_pkg::SCP_IDLE;
         bit_cnt_reg    <= '0;
         instr_reg      <= '0;
         rx_reg         <= '0;
         addr_reg       <= '0;
         left_reg       <= '0;
         stream_reg     <= 1'b0;
         rw_reg         <= 1'b0;
         op_lsb_reg     <= 1'b0;
         instr_done_reg <= 1'b0;
         xfer_done_reg  <= 1'b0;
         rd_req_reg     <= 1'b0;
         rd_addr_reg    <= '0;
         rd_src_reg     <= 1'b0;
         push_reg       <= 1'b0;
         push_word_reg  <= '0;
         cfg_reg        <= scp_pkg::CFG_RESET;                             // [RULE8]
      end else begin
         rd_req_reg <= 1'b0;
         push_reg   <= 1'b0;
         case (state_reg)
            scp_pkg::SCP_IDLE: begin
               if (cs_fall) begin                                         // [RULE9]
                  state_reg      <= scp_pkg::SCP_INSTR;
                  bit_cnt_reg    <= '0;
                  instr_done_reg <= 1'b0;
                  xfer_done_reg  <= 1'b0;
                  op_lsb_reg     <= cfg_reg[scp_pkg::CFG_LSB_BIT];         // [RULE24]
               end
            end
            scp_pkg::SCP_INSTR, scp_pkg::SCP_DATA: begin
               if (cs_rise) begin
                  // Mid-byte release drops the partial byte and the whole transfer
                  if (bit_cnt_reg[2:0] != 3'h0) begin
                     state_reg <= scp_pkg::SCP_IDLE;                      // [RULE12]
                  end else if (xfer_done_reg || stream_reg || bit_cnt_reg == scp_pkg::CNT_ZERO
                               && state_reg == scp_pkg::SCP_INSTR) begin
                     state_reg <= scp_pkg::SCP_IDLE;                      // [RULE27] [RULE13]
                  end else begin
                     state_reg <= scp_pkg::SCP_STALL;                     // [RULE10]
                  end
               end else if (sclk_rise && state_reg == scp_pkg::SCP_INSTR) begin
                  instr_reg   <= instr_next;
                  bit_cnt_reg <= bit_cnt_reg + scp_pkg::CNT_ONE;
                  if (bit_cnt_reg == scp_pkg::INSTR_LAST) begin
                     state_reg      <= scp_pkg::SCP_DATA;
                     bit_cnt_reg    <= '0;
                     instr_done_reg <= 1'b1;
                     rw_reg         <= instr_next[scp_pkg::RW_BIT];        // [RULE16]
                     left_reg       <= instr_next[scp_pkg::CNT_HI_BIT:scp_pkg::CNT_LO_BIT]; // [RULE14]
                     stream_reg     <= is_stream(instr_next[scp_pkg::CNT_HI_BIT:scp_pkg::CNT_LO_BIT]);
                     addr_reg       <= first_addr;
                     rd_req_reg     <= instr_next[scp_pkg::RW_BIT];        // [RULE19]
                     rd_addr_reg    <= first_addr;
                     rd_src_reg     <= readback_active_sel;                // [RULE21]
                  end
               end else if (sclk_rise && !xfer_done_reg) begin
                  rx_reg      <= rx_next;                                 // [RULE3]
                  bit_cnt_reg <= bit_cnt_reg + scp_pkg::CNT_ONE;
                  if (bit_cnt_reg == scp_pkg::BYTE_LAST) begin
                     bit_cnt_reg <= '0;
                     addr_reg    <= next_addr;
                     if (!rw_reg && addr_reg == scp_pkg::CFG_ADDR) begin
                        cfg_reg <= rx_next;                               // [RULE22]
                     end else if (!rw_reg) begin
                        push_reg      <= 1'b1;                            // [RULE17]
                        push_word_reg <= {addr_reg, rx_next};
                     end
                     if (!stream_reg && left_reg == 2'h0) begin
                        xfer_done_reg <= 1'b1;
                     end else begin
                        if (!stream_reg) begin
                           left_reg <= left_reg - 2'h1;
                        end
                        rd_req_reg  <= rw_reg;                            // [RULE20]
                        rd_addr_reg <= next_addr;
                     end
                  end
               end
            end
            scp_pkg::SCP_STALL: begin
               // A short burst of clocks then release lands mid-byte and aborts
               if (cs_fall) begin
                  state_reg <= instr_done_reg ? scp_pkg::SCP_DATA : scp_pkg::SCP_INSTR; // [RULE10] [RULE11]
               end
            end
            default: begin
               state_reg <= scp_pkg::SCP_IDLE;
            end
         endcase
      end
   end

   // Read byte load and falling-edge shifter
   always_ff @(posedge ref_clk) begin
      if (srst) begin
         rd_load_reg <= 1'b0;
         tx_reg      <= '0;
         tx_bit_reg  <= 1'b0;
      end else begin
         rd_load_reg <= rd_req_reg;
         if (rd_load_reg) begin
            tx_reg <= (rd_addr_reg == scp_pkg::CFG_ADDR) ? cfg_reg : rd_data;
         end else if (sclk_fall && state_reg == scp_pkg::SCP_DATA && rw_reg) begin
            tx_bit_reg <= op_lsb_reg ? tx_reg[0] : tx_reg[7];            // [RULE3] [RULE20]
            tx_reg     <= op_lsb_reg ? {1'b0, tx_reg[7:1]} : {tx_reg[6:0], 1'b0};
         end
      end
   end

   // Driver enables; released as soon as chip select is seen high
   always_ff @(posedge ref_clk) begin
      if (srst) begin
         oe_reg      <= 1'b0;
         rd_end_reg  <= 1'b0;
         sdio_oe_reg <= 1'b0;
         sdo_oe_reg  <= 1'b0;
         busy_reg    <= 1'b0;
      end else begin
         // Last read bit must stand until the host samples it at the next fall
         rd_end_reg  <= (state_reg == scp_pkg::SCP_DATA) && (rd_end_reg || (xfer_done_reg && sclk_fall)); // [RULE20]
         oe_reg      <= cs_low && rw_reg && !rd_end_reg && state_reg == scp_pkg::SCP_DATA; // [RULE7]
         sdio_oe_reg <= oe_reg && cs_low && !cfg_reg[scp_pkg::CFG_UNI_BIT];  // [RULE5]
         sdo_oe_reg  <= oe_reg && cs_low && cfg_reg[scp_pkg::CFG_UNI_BIT];   // [RULE6]
         busy_reg    <= (state_reg != scp_pkg::SCP_IDLE);
      end
   end

   // The serial side cannot pause, so a full buffer loses the byte and says so
   always_ff @(posedge ref_clk) begin
      if (srst) begin
         overrun_reg <= 1'b0;
      end else begin
         overrun_reg <= push_reg && !fifo_in_ready;
      end
   end

   scp_fifo #(
      .WIDTH (scp_pkg::WORD_W),
      .DEPTH (FIFO_DEPTH)
   ) u_fifo (
      .ref_clk   (ref_clk),
      .srst      (srst),
      .in_valid  (push_reg),
      .in_ready  (fifo_in_ready),
      .in_data   (push_word_reg),
      .out_valid (fifo_out_valid),
      .out_ready (buf_wr_ready),
      .out_data  (fifo_out_data)
   );

   assign sdio_out        = tx_bit_reg;
   assign sdo_out         = tx_bit_reg;
   assign sdio_oe         = sdio_oe_reg;
   assign sdo_oe          = sdo_oe_reg;
   assign spi_selected    = spi_sel_reg;
   assign i2c_target_addr = i2c_addr_reg;
   assign lsb_first       = cfg_reg[scp_pkg::CFG_LSB_BIT];
   assign unidir_mode     = cfg_reg[scp_pkg::CFG_UNI_BIT];
   assign busy            = busy_reg;
   assign buf_wr_valid    = fifo_out_valid;
   assign buf_wr_addr     = fifo_out_data[scp_pkg::WORD_W-1:scp_pkg::BYTE_W];
   assign buf_wr_data     = fifo_out_data[scp_pkg::BYTE_W-1:0];
   assign wr_overrun      = overrun_reg;
   assign rd_req          = rd_req_reg;
   assign rd_addr         = rd_addr_reg;
   assign rd_src_active   = rd_src_reg;
endmodule
